//--- hdl/spp_pkg.sv
// spp_pkg: shared constants for the serial pause link (device end and master end)
// assumes both ends run on their own 10 MHz system clock
package spp_pkg;
  localparam int unsigned SPP_SYS_CLK_HZ   = 10_000_000;
  localparam int unsigned SPP_WORD_BITS    = 8;
  localparam int unsigned SPP_SCK_HALF_DIV = 4;
  localparam logic [7:0]  SPP_RESET_BYTE   = 8'h00;
  localparam logic [7:0]  SPP_IDLE_TX      = 8'hFF;
endpackage

//--- hdl/spp_if.sv
// spp_if: serial link wires between the master end and the device end
// resolves the shared data-out wire here from the enable, reading high when released
`timescale 1ns/1ps
interface spp_if;
  logic sck;
  logic cs_n;
  logic pause_n;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;
  assign miso = miso_oe ? miso_o : 1'b1;
  modport dev (input sck, input cs_n, input pause_n, input mosi, output miso_o, output miso_oe);
  modport mst (output sck, output cs_n, output pause_n, output mosi, input miso);
endinterface

//--- hdl/spp_device.sv
// spp_device: slave end of the serial link with pause support, plus its pin synchroniser
// assumes link pins are asynchronous to clk_sys_in and are synchronised here
`timescale 1ns/1ps
module spp_device
  import spp_pkg::*;
#(
  parameter int unsigned WORD_BITS = SPP_WORD_BITS
)(
  input  wire logic                 clk_sys_in,
  input  wire logic                 rst_n_in,
  spp_if.dev                        link,
  input  wire logic [WORD_BITS-1:0] tx_byte_in,
  output logic      [WORD_BITS-1:0] rx_byte_out,
  output logic                      rx_valid_out,
  output logic                      paused_out,
  output logic                      active_out
);
  localparam int CW = $clog2(WORD_BITS);
  // synchroniser lanes, high to low: clock, select, pause, data
  localparam int unsigned NPIN    = 4;
  // idle levels of the lanes: clock low, select and pause high, data low
  localparam logic [3:0]  PIN_RST = 4'h6;

  typedef struct packed {
    logic                 sck_q;
    logic                 paused;
    logic                 active;
    logic [CW-1:0]        bit_cnt;
    logic [WORD_BITS-1:0] rx_sh;
    logic [WORD_BITS-1:0] tx_sh;
    logic [WORD_BITS-1:0] rx_byte;
    logic                 rx_valid;
    logic                 miso;
    logic                 miso_oe;
  } spp_dev_t;

  spp_dev_t             st_r;
  spp_dev_t             st_nxt;
  logic     [NPIN-1:0]  pins_s;
  logic                 sck;
  logic                 cs_n;
  logic                 pse_n;
  logic                 mosi;
  logic                 rise;
  logic                 fall;
  logic                 selected;
  logic                 pause_set;
  logic                 pause_clr;
  logic                 drop;
  logic                 run;
  logic [WORD_BITS-1:0] rx_new;

  // every link pin crosses into clk_sys_in here before any logic reads it
  spp_sync2 #(
    .WIDTH   (NPIN),
    .RST_VAL (PIN_RST)
  ) spp_sync2_i (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .d_in       ({link.sck, link.cs_n, link.pause_n, link.mosi}),
    .q_out      (pins_s)
  );

  assign sck       = pins_s[3];
  assign cs_n      = pins_s[2];
  assign pse_n     = pins_s[1];
  assign mosi      = pins_s[0];
  assign rise      = sck & ~st_r.sck_q;
  assign fall      = ~sck & st_r.sck_q;
  assign selected  = ~cs_n;
  // pause changes only while selected with the clock low, so no edge is half taken
  assign pause_set = selected & ~sck & ~pse_n & st_r.active;
  assign pause_clr = selected & ~sck & pse_n;
  // a deselect ends the transaction only when it is not paused
  assign drop      = cs_n & ~st_r.paused;
  // shifting runs only while selected, not paused and with pause input high
  assign run       = selected & ~st_r.paused & pse_n;
  assign rx_new    = {st_r.rx_sh[WORD_BITS-2:0], mosi};

  always_comb
  begin
    st_nxt          = st_r;
    // edges keep being tracked in pause, so none is replayed after release
    st_nxt.sck_q    = sck;
    st_nxt.rx_valid = 1'b0;
    if (pause_set)
      st_nxt.paused = 1'b1;
    else if (pause_clr)
      st_nxt.paused = 1'b0;
    if (drop)
    begin
      st_nxt.active  = 1'b0;
      st_nxt.bit_cnt = '0;
      st_nxt.rx_sh   = SPP_RESET_BYTE;
    end
    else if (run)
    begin
      if (!st_r.active)
      begin
        st_nxt.active = 1'b1;
        st_nxt.tx_sh  = tx_byte_in;
        st_nxt.miso   = tx_byte_in[WORD_BITS-1];
      end
      if (rise)
      begin
        st_nxt.rx_sh = rx_new;
        if (st_r.bit_cnt == CW'(WORD_BITS-1))
        begin
          st_nxt.bit_cnt  = '0;
          st_nxt.rx_byte  = rx_new;
          st_nxt.rx_valid = 1'b1;
        end
        else
          st_nxt.bit_cnt = st_r.bit_cnt + 1'b1;
      end
      if (fall && st_r.active)
      begin
        if (st_r.bit_cnt == '0)
        begin
          st_nxt.tx_sh = tx_byte_in;
          st_nxt.miso  = tx_byte_in[WORD_BITS-1];
        end
        else
        begin
          st_nxt.tx_sh = {st_r.tx_sh[WORD_BITS-2:0], 1'b1};
          st_nxt.miso  = st_r.tx_sh[WORD_BITS-2];
        end
      end
    end
    // while paused neither the drop nor the run branch above fires: counter and shifters hold
    // enable is registered and drops in the same edge as pause is taken
    st_nxt.miso_oe = selected & ~st_nxt.paused;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_r         <= '0;
      st_r.rx_sh   <= SPP_RESET_BYTE;
      st_r.tx_sh   <= SPP_IDLE_TX;
      st_r.rx_byte <= SPP_RESET_BYTE;
      st_r.miso    <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  // the shared data wire reads released whenever the enable is low
  assign link.miso_o  = st_r.miso;
  assign link.miso_oe = st_r.miso_oe;
  assign rx_byte_out  = st_r.rx_byte;
  assign rx_valid_out = st_r.rx_valid;
  assign paused_out   = st_r.paused;
  assign active_out   = st_r.active;
endmodule

// spp_sync2: two flip-flops per lane for pins from outside the clock domain
module spp_sync2
  import spp_pkg::*;
#(
  parameter int unsigned      WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)(
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } spp_sync_t;

  spp_sync_t st_r;
  spp_sync_t st_nxt;

  // the first stage may go metastable, so only the second is read outside
  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.meta = d_in;
    st_nxt.sync = st_r.meta;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_r.meta <= RST_VAL;
      st_r.sync <= RST_VAL;
    end
    else
      st_r <= st_nxt;
  end

  assign q_out = st_r.sync;
endmodule

//--- hdl/spp_master.sv
// spp_master: master end driving clock, select, pause and data (mode 0)
// assumes miso is asynchronous and passes two flip-flops before use
`timescale 1ns/1ps
module spp_master
  import spp_pkg::*;
#(
  parameter int unsigned WORD_BITS = SPP_WORD_BITS,
  parameter int unsigned HALF_DIV  = SPP_SCK_HALF_DIV
)(
  input  wire logic                 clk_sys_in,
  input  wire logic                 rst_n_in,
  spp_if.mst                        link,
  input  wire logic                 start_in,
  input  wire logic [WORD_BITS-1:0] tx_byte_in,
  input  wire logic                 last_in,
  input  wire logic                 pause_req_in,
  input  wire logic                 desel_in,
  output logic                      ready_out,
  output logic      [WORD_BITS-1:0] rx_byte_out,
  output logic                      rx_valid_out,
  output logic                      paused_out
);
  localparam int CW = $clog2(WORD_BITS);
  localparam int DW = $clog2(HALF_DIV + 1);

  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_XFER  = 4'b0010,
    S_WAIT  = 4'b0100,
    S_PAUSE = 4'b1000
  } spp_mst_state_t;

  typedef struct packed {
    spp_mst_state_t       state;
    logic [1:0]           miso_s;
    logic [DW-1:0]        div;
    logic                 sck;
    logic                 cs_n;
    logic                 pse_n;
    logic                 mosi;
    logic                 last;
    logic [CW-1:0]        bit_cnt;
    logic [WORD_BITS-1:0] tx_sh;
    logic [WORD_BITS-1:0] rx_sh;
    logic [WORD_BITS-1:0] rx_byte;
    logic                 rx_valid;
  } spp_mst_t;

  spp_mst_t st_r;
  spp_mst_t st_nxt;
  logic     tick;

  assign tick = (st_r.div == DW'(HALF_DIV - 1));

  always_comb
  begin
    st_nxt          = st_r;
    st_nxt.miso_s   = {st_r.miso_s[0], link.miso};
    st_nxt.rx_valid = 1'b0;
    st_nxt.div      = tick ? '0 : st_r.div + 1'b1;
    case (st_r.state)
      S_IDLE:
      begin
        st_nxt.div = '0;
        if (start_in)
        begin
          st_nxt.state   = S_XFER;
          st_nxt.cs_n    = 1'b0;
          st_nxt.tx_sh   = {tx_byte_in[WORD_BITS-2:0], 1'b0};
          st_nxt.mosi    = tx_byte_in[WORD_BITS-1];
          st_nxt.last    = last_in;
          st_nxt.bit_cnt = '0;
        end
      end
      S_XFER:
      begin
        if (tick && !st_r.sck && pause_req_in)
        begin
          // clock is low here, so pause goes low safely
          st_nxt.state = S_PAUSE;
          st_nxt.pse_n = 1'b0;
          st_nxt.div   = '0;
        end
        else if (tick && !st_r.sck)
          st_nxt.sck = 1'b1;
        else if (tick)
        begin
          st_nxt.sck   = 1'b0;
          st_nxt.rx_sh = {st_r.rx_sh[WORD_BITS-2:0], st_r.miso_s[1]};
          if (st_r.bit_cnt == CW'(WORD_BITS-1))
          begin
            st_nxt.rx_byte  = {st_r.rx_sh[WORD_BITS-2:0], st_r.miso_s[1]};
            st_nxt.rx_valid = 1'b1;
            st_nxt.state    = S_WAIT;
          end
          else
          begin
            st_nxt.bit_cnt = st_r.bit_cnt + 1'b1;
            st_nxt.mosi    = st_r.tx_sh[WORD_BITS-1];
            st_nxt.tx_sh   = {st_r.tx_sh[WORD_BITS-2:0], 1'b0};
          end
        end
      end
      S_WAIT:
      begin
        st_nxt.div = '0;
        if (st_r.last)
        begin
          st_nxt.state = S_IDLE;
          st_nxt.cs_n  = 1'b1;
        end
        else if (start_in)
        begin
          st_nxt.state   = S_XFER;
          st_nxt.tx_sh   = {tx_byte_in[WORD_BITS-2:0], 1'b0};
          st_nxt.mosi    = tx_byte_in[WORD_BITS-1];
          st_nxt.last    = last_in;
          st_nxt.bit_cnt = '0;
        end
      end
      S_PAUSE:
      begin
        // select follows desel while paused; release needs reselect first
        st_nxt.div  = '0;
        st_nxt.cs_n = desel_in;
        if (!pause_req_in && !desel_in && !st_r.cs_n)
        begin
          st_nxt.state = S_XFER;
          st_nxt.pse_n = 1'b1;
        end
      end
      default:
        st_nxt.state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_r       <= '0;
      st_r.state <= S_IDLE;
      st_r.cs_n  <= 1'b1;
      st_r.pse_n <= 1'b1;
      st_r.tx_sh <= SPP_IDLE_TX;
    end
    else
      st_r <= st_nxt;
  end

  assign link.sck     = st_r.sck;
  assign link.cs_n    = st_r.cs_n;
  assign link.pause_n = st_r.pse_n;
  assign link.mosi    = st_r.mosi;
  assign ready_out    = (st_r.state == S_IDLE) || (st_r.state == S_WAIT && !st_r.last);
  assign rx_byte_out  = st_r.rx_byte;
  assign rx_valid_out = st_r.rx_valid;
  assign paused_out   = (st_r.state == S_PAUSE);
endmodule

//--- tb/spp_assertions.sv
// spp_assertions: pause checks on the link between master end and device end
// assumes its inputs are the wires of the interface joining the two ends
`timescale 1ns/1ps
module spp_assertions (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic pause_n,
  input wire logic miso_oe
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  a_pause_sck_low: assert property ($fell(pause_n) |-> !sck)
    else $error("pause entered with clock high");
  a_resume_sck_low: assert property ($rose(pause_n) |-> !sck)
    else $error("pause left with clock high");
  a_pause_when_sel: assert property ($fell(pause_n) |-> !cs_n)
    else $error("pause entered while deselected");
  a_resume_when_sel: assert property ($rose(pause_n) |-> !cs_n)
    else $error("pause left while deselected");
  a_out_release: assert property ($fell(pause_n) |-> ##[1:8] !miso_oe)
    else $error("data output still driven in pause");
  a_out_stays_off: assert property (!pause_n && !miso_oe |=> !miso_oe || pause_n)
    else $error("data output driven again in pause");
  a_desel_keeps: assert property (cs_n && !pause_n |=> !pause_n)
    else $error("pause dropped while deselected");
  a_out_resumes: assert property ($rose(pause_n) |-> ##[1:8] miso_oe)
    else $error("data output not driven after resume");

  c_pause: cover property ($fell(pause_n));
  c_desel_pause: cover property (cs_n && !pause_n);
  c_resume: cover property ($rose(pause_n) && !cs_n);
endmodule

//--- tb/spi_slave_pause_control_tb_top.sv
// testbench: master end and device end joined, plus a device driven by the bench
// assumes a 10 MHz system clock; the bench link clock has an 800 ns period
`timescale 1ns/1ps
module spi_slave_pause_control_tb_top
  import spp_pkg::*;
;
  logic       clk_sys_in = 1'b0;
  logic       rst_n_in   = 1'b0;
  logic       start      = 1'b0;
  logic       last       = 1'b0;
  logic       preq       = 1'b0;
  logic       desel      = 1'b0;
  logic [7:0] mtx        = 8'h00;
  logic       m_ready;
  logic       m_rxv;
  logic       m_paused;
  logic       d_paused;
  logic       d_active;
  logic       f_paused;
  logic       f_active;
  logic       d_rxv;
  logic       f_rxv;
  logic [7:0] m_rx;
  logic [7:0] d_rx;
  logic [7:0] f_rx;
  int         checked    = 0;
  int         n_mismatch = 0;
  int         n_d_rx     = 0;
  int         n_f_rx     = 0;
  spp_if lnk ();
  spp_if lnk2 ();

  always #50 clk_sys_in = ~clk_sys_in;

  // bytes announced by each device end
  always @(posedge clk_sys_in)
  begin
    if (d_rxv === 1'b1)
      n_d_rx++;
    if (f_rxv === 1'b1)
      n_f_rx++;
  end

  spp_master spp_master_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .link(lnk),
    .start_in(start), .tx_byte_in(mtx), .last_in(last), .pause_req_in(preq),
    .desel_in(desel), .ready_out(m_ready), .rx_byte_out(m_rx), .rx_valid_out(m_rxv),
    .paused_out(m_paused));
  spp_device spp_device_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .link(lnk),
    .tx_byte_in(8'h5A), .rx_byte_out(d_rx), .rx_valid_out(d_rxv), .paused_out(d_paused),
    .active_out(d_active));
  spp_device spp_device_f_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .link(lnk2),
    .tx_byte_in(8'hC3), .rx_byte_out(f_rx), .rx_valid_out(f_rxv), .paused_out(f_paused),
    .active_out(f_active));
  spp_assertions spp_assertions_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .sck(lnk.sck), .cs_n(lnk.cs_n), .pause_n(lnk.pause_n), .miso_oe(lnk.miso_oe));

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one byte through the master, optionally paused and deselected in mid-byte
  task automatic xfer(input logic [7:0] b, input logic l, input logic p, input logic d);
    mtx   <= b;
    last  <= l;
    start <= 1'b1;
    tick(1);
    for (int i = 0; i < 50 && m_ready !== 1'b1; i++) tick(1);
    start <= 1'b0;
    if (p)
    begin
      tick(20);
      preq <= 1'b1;
      for (int i = 0; i < 50 && m_paused !== 1'b1; i++) tick(1);
      tick(8);
      chk({7'h00, d_paused}, 8'h01);
      chk({7'h00, lnk.sck}, 8'h00);
      chk({7'h00, lnk.miso}, 8'h01);
      chk({7'h00, lnk.miso_oe}, 8'h00);
      if (d)
      begin
        desel <= 1'b1;
        tick(16);
        chk({7'h00, lnk.cs_n}, 8'h01);
        chk({7'h00, d_active}, 8'h01);
        desel <= 1'b0;
      end
      preq <= 1'b0;
    end
    for (int i = 0; i < 300 && m_rxv !== 1'b1; i++) tick(1);
    chk(m_rx, 8'h5A);
    tick(12);
    chk(d_rx, b);
  endtask

  // one bit on the bench-driven link, 800 ns per clock period
  task automatic fb(input logic b);
    lnk2.mosi <= b;
    tick(4);
    lnk2.sck <= 1'b1;
    tick(4);
    lnk2.sck <= 1'b0;
  endtask

  initial
  begin
    lnk2.sck     <= 1'b0;
    lnk2.cs_n    <= 1'b1;
    lnk2.pause_n <= 1'b1;
    lnk2.mosi    <= 1'b0;
    tick(16);
    rst_n_in <= 1'b1;
    tick(4);
    xfer(8'hA5, 1'b0, 1'b0, 1'b0);
    xfer(8'h3C, 1'b0, 1'b1, 1'b0);
    xfer(8'hC3, 1'b1, 1'b1, 1'b1);
    chk(8'(n_d_rx), 8'h03);
    $display("test master pair done");
    lnk2.cs_n <= 1'b0;
    tick(8);
    for (int i = 7; i >= 4; i--) fb(1'(8'h96 >> i));
    tick(4);
    chk({7'h00, lnk2.miso_oe}, 8'h01);
    lnk2.pause_n <= 1'b0;
    tick(8);
    chk({7'h00, f_paused}, 8'h01);
    chk({7'h00, lnk2.miso_oe}, 8'h00);
    for (int i = 0; i < 4; i++) fb(i[0]);
    lnk2.cs_n <= 1'b1;
    tick(8);
    chk({7'h00, f_active}, 8'h01);
    lnk2.cs_n <= 1'b0;
    tick(8);
    lnk2.pause_n <= 1'b1;
    tick(8);
    for (int i = 3; i >= 0; i--) fb(1'(8'h96 >> i));
    tick(12);
    chk(f_rx, 8'h96);
    chk(8'(n_f_rx), 8'h01);
    $display("test bench link done");
    report_and_stop();
  end

  initial
  begin
    tick(20000);
    n_mismatch++;
    report_and_stop();
  end
endmodule
